/* File: rtl/sar_adc_pkg.sv */
// constants, types and state record of the successive-approximation converter control
package sar_adc_pkg;
	localparam int unsigned ADDR_W = 20;
	// special-function register byte addresses
	localparam logic [19:0] ADDR_PCLK_EN = 20'hF00F0;
	localparam logic [19:0] ADDR_ADM0 = 20'hFFF30;
	localparam logic [19:0] ADDR_MODE2 = 20'hFFF10;
	localparam logic [19:0] ADDR_CHAN_SEL = 20'hFFF31;
	localparam logic [19:0] ADDR_RES_WORD = 20'hFFF1E;
	localparam logic [19:0] ADDR_RES_BYTE = 20'hFFF1F;
	// field positions
	localparam int unsigned PCE_CONV_EN = 5;
	localparam int unsigned ADM0_START = 7;
	localparam int unsigned ADM0_CMP_EN = 0;
	localparam int unsigned MODE2_RES8 = 0;
	localparam int unsigned CHAN_INT_REF = 7;
	// reset values
	localparam logic [7:0] PCE_RST = 8'h00;
	localparam logic [9:0] SAR_RST = 10'h000;
	// search constants
	localparam logic [9:0] TAP_MID = 10'h200;
	localparam logic [3:0] IDX_MSB = 4'h9;
	localparam logic [3:0] IDX_LAST10 = 4'h0;
	localparam logic [3:0] IDX_LAST8 = 4'h2;
	localparam int unsigned NUM_PINS = 11;
	// cycle counts; a step leaves room for the two-stage comparator synchroniser
	localparam logic [3:0] SAMPLE_LAST = 4'h7;
	localparam logic [3:0] STEP_LAST = 4'h3;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_TRIAL = 2'b10
	} conv_state_t;

	typedef struct packed {
		logic [7:0] pce;
		logic run;
		logic cmp_en;
		logic res8;
		logic ref_sel;
		logic [3:0] chan;
		conv_state_t st;
		logic [9:0] sar;
		logic [3:0] idx;
		logic [3:0] cnt;
		logic [9:0] result;
		logic irq;
		logic [15:0] rdata;
		logic cmp_s1;
		logic cmp_s2;
	} adc_state_t;

	typedef struct packed {
		logic [9:0] tap;
		logic sample;
		logic int_ref_sel;
		logic [3:0] chan_sel;
	} afe_ctrl_t;
endpackage

/* File: rtl/sar_adc_sequencer.sv */
// successive-approximation converter sequencer with its special-function registers
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer
	import sar_adc_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_wmask_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_rd_i,
	output logic [15:0] sfr_rdata_o,
	input wire logic cmp_i,
	output afe_ctrl_t afe_o,
	output logic [NUM_PINS-1:0] analog_route_o,
	output logic conv_clock_enable_o,
	output logic conversion_end_irq_o
);
	adc_state_t s_r;
	adc_state_t s_nxt;
	logic done;
	logic [9:0] sar_fin;
	logic [7:0] nv;
	logic conv_on;

	// byte or single-bit write: the mask says which bits the store touches
	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] m, input logic [7:0] d);
		merge = (old & ~m) | (d & m);
	endfunction

	assign conv_on = s_r.pce[PCE_CONV_EN];

	always_comb begin
		s_nxt = s_r;
		done = 1'b0;
		sar_fin = s_r.sar;
		nv = 8'h00;
		s_nxt.irq = 1'b0;
		s_nxt.cmp_s1 = cmp_i;
		s_nxt.cmp_s2 = s_r.cmp_s1;

		// search engine: sample phase, then one trial bit per step
		case (s_r.st)
			ST_SAMPLE: begin
				if (s_r.cnt == 4'h0) begin
					s_nxt.st = ST_TRIAL;
					s_nxt.sar = TAP_MID;
					s_nxt.idx = IDX_MSB;
					s_nxt.cnt = STEP_LAST;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			ST_TRIAL: begin
				if (s_r.cnt != 4'h0) begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end else begin
					sar_fin[s_r.idx] = s_r.cmp_s2;
					s_nxt.sar = sar_fin;
					// at-or-below, so a resolution change mid-run can never walk the index past zero
					if (s_r.idx <= (s_r.res8 ? IDX_LAST8 : IDX_LAST10)) begin
						done = 1'b1;
						s_nxt.result = sar_fin;
						s_nxt.irq = 1'b1;
						s_nxt.run = 1'b0;
						s_nxt.st = ST_IDLE;
					end else begin
						s_nxt.idx = s_r.idx - 4'h1;
						s_nxt.sar[s_r.idx - 4'h1] = 1'b1;
						s_nxt.cnt = STEP_LAST;
					end
				end
			end
			ST_IDLE: begin
				s_nxt.cnt = 4'h0;
			end
			default: begin
				s_nxt.st = ST_IDLE;
			end
		endcase
		// the enable register sits outside the converter and is never gated
		if (sfr_wr_i && sfr_addr_i == ADDR_PCLK_EN) begin
			s_nxt.pce = merge(s_r.pce, sfr_wmask_i, sfr_wdata_i);
		end
		if (sfr_wr_i && conv_on) begin
			case (sfr_addr_i)
				ADDR_ADM0: begin
					nv = merge({s_r.run, 6'h00, s_r.cmp_en}, sfr_wmask_i, sfr_wdata_i);
					s_nxt.cmp_en = nv[ADM0_CMP_EN];
					if (!nv[ADM0_START]) begin
						// an abort leaves a same-cycle end pulse standing: the hardware event wins
						s_nxt.run = 1'b0;
						s_nxt.st = ST_IDLE;
					end else if (!s_r.run && s_r.cmp_en) begin
						s_nxt.run = 1'b1;
						s_nxt.st = ST_SAMPLE;
						s_nxt.cnt = SAMPLE_LAST;
						s_nxt.sar = SAR_RST;
						s_nxt.idx = IDX_MSB;
					end
				end
				ADDR_MODE2: begin
					nv = merge({7'h00, s_r.res8}, sfr_wmask_i, sfr_wdata_i);
					s_nxt.res8 = nv[MODE2_RES8];
				end
				ADDR_CHAN_SEL: begin
					nv = merge({s_r.ref_sel, 3'h0, s_r.chan}, sfr_wmask_i, sfr_wdata_i);
					s_nxt.ref_sel = nv[CHAN_INT_REF];
					s_nxt.chan = nv[3:0];
				end
				default: begin
					nv = 8'h00;
				end
			endcase
		end
		// the converter has no clock of its own here, so a held reset stands in for the stopped clock;
		// the new enable value is used so the clear lands on the same edge as the disabling write
		if (!s_nxt.pce[PCE_CONV_EN]) begin
			s_nxt.run = 1'b0;
			s_nxt.cmp_en = 1'b0;
			s_nxt.res8 = 1'b0;
			s_nxt.ref_sel = 1'b0;
			s_nxt.chan = 4'h0;
			s_nxt.st = ST_IDLE;
			s_nxt.sar = SAR_RST;
			s_nxt.idx = 4'h0;
			s_nxt.cnt = 4'h0;
			s_nxt.result = SAR_RST;
			s_nxt.irq = 1'b0;
		end
		// read data is registered, so it stands until the next read strobe
		if (sfr_rd_i) begin
			case (sfr_addr_i)
				ADDR_PCLK_EN: begin
					s_nxt.rdata = {8'h00, s_r.pce};
				end
				ADDR_ADM0: begin
					s_nxt.rdata = {8'h00, s_r.run, 6'h00, s_r.cmp_en};
				end
				ADDR_MODE2: begin
					s_nxt.rdata = {15'h0000, s_r.res8};
				end
				ADDR_CHAN_SEL: begin
					s_nxt.rdata = {8'h00, s_r.ref_sel, 3'h0, s_r.chan};
				end
				ADDR_RES_WORD: begin
					s_nxt.rdata = {s_r.result, 6'h00};
				end
				ADDR_RES_BYTE: begin
					s_nxt.rdata = {8'h00, s_r.result[9:2]};
				end
				default: begin
					s_nxt.rdata = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign sfr_rdata_o = s_r.rdata;
	assign afe_o.tap = s_r.sar;
	assign afe_o.sample = (s_r.st == ST_SAMPLE);
	assign afe_o.int_ref_sel = conv_on && s_r.ref_sel;
	assign afe_o.chan_sel = s_r.chan;
	assign conv_clock_enable_o = conv_on;
	assign conversion_end_irq_o = s_r.irq;

	// an out-of-range channel routes no pin rather than wrapping onto one
	generate
		for (genvar i = 0; i < NUM_PINS; i++) begin : g_route
			assign analog_route_o[i] = conv_on && !s_r.ref_sel && s_r.chan == 4'(i);
		end
	endgenerate

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	mid_tap_a: assert property ((s_r.st == ST_SAMPLE && s_r.cnt == 4'h0 && !sfr_wr_i) |=> afe_o.tap == TAP_MID)
		else $error("first trial did not use mid-scale tap");
	second_tap_a: assert property ((s_r.st == ST_TRIAL && s_r.idx == IDX_MSB && s_r.cnt == 4'h0 && conv_on
		&& !sfr_wr_i) |=> (afe_o.tap[9] == $past(s_r.cmp_s2) && afe_o.tap[8] && s_r.idx == 4'h8))
		else $error("bit 8 trial tap wrong");
	trial_keep_a: assert property ((s_r.st == ST_TRIAL && s_r.cnt == 4'h0 && !done && conv_on && !sfr_wr_i)
		|=> s_r.sar[s_r.idx + 4'h1] == $past(s_r.cmp_s2))
		else $error("trial bit not decided by comparator");
	stop_8bit_a: assert property (s_r.st == ST_TRIAL && s_r.res8 && s_r.idx == IDX_LAST8 && s_r.cnt == 4'h0
		&& conv_on && !sfr_wr_i |=> s_r.st == ST_IDLE && !s_r.run && s_r.sar[1:0] == 2'b00)
		else $error("8-bit conversion did not stop after bit 2");
	result_load_a: assert property (done && s_nxt.pce[PCE_CONV_EN] |=> s_r.result == $past(sar_fin) && !s_r.run)
		else $error("result not loaded or start not cleared");
	end_irq_a: assert property (done && s_nxt.pce[PCE_CONV_EN] |=> conversion_end_irq_o ##1 !conversion_end_irq_o)
		else $error("end interrupt not a single pulse");
	word_low_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_RES_WORD |=> sfr_rdata_o[5:0] == 6'h00
		&& sfr_rdata_o[15:6] == $past(s_r.result))
		else $error("result word layout wrong");
	byte_top_a: assert property (sfr_rd_i && sfr_addr_i == ADDR_RES_BYTE |=> sfr_rdata_o[7:0]
		== $past(s_r.result[9:2]))
		else $error("result byte wrong");
	one_pin_a: assert property ($onehot0(analog_route_o) && !(afe_o.int_ref_sel && |analog_route_o))
		else $error("more than one conversion source routed");
	hold_sample_a: assert property (s_r.st == ST_TRIAL |-> !afe_o.sample && s_r.run)
		else $error("sample not held during trials");
	tap_stable_a: assert property ((s_r.st == ST_TRIAL && s_r.cnt != 4'h0 && s_nxt.pce[PCE_CONV_EN]) |=> $stable(afe_o.tap))
		else $error("tap moved inside a step");
	off_reset_a: assert property (!conv_on |=> (!s_r.run && s_r.result == SAR_RST && s_r.st == ST_IDLE)
		or conv_on)
		else $error("disabled converter left out of reset");

	// register side
	pce_write_a: assert property (sfr_wr_i && sfr_addr_i == ADDR_PCLK_EN
		|=> s_r.pce == (($past(s_r.pce) & ~$past(sfr_wmask_i)) | ($past(sfr_wdata_i) & $past(sfr_wmask_i))))
		else $error("enable register write did not merge");
	dis_write_a: assert property (!conv_on && sfr_wr_i && sfr_addr_i == ADDR_MODE2
		|=> !s_r.res8)
		else $error("write to disabled converter took effect");
	dis_read_a: assert property (!conv_on && sfr_rd_i && sfr_addr_i == ADDR_RES_WORD
		|=> sfr_rdata_o == 16'h0000)
		else $error("disabled converter result not at reset value");
	rdata_hold_a: assert property (!sfr_rd_i
		|=> $stable(sfr_rdata_o))
		else $error("read data moved without a read");
	unmapped_a: assert property (sfr_rd_i && sfr_addr_i == 20'hFFFFF
		|=> sfr_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	start_ign_a: assert property (sfr_wr_i && conv_on && sfr_addr_i == ADDR_ADM0 && !s_r.run && !s_r.cmp_en
		|=> !s_r.run)
		else $error("start accepted with comparator off");
	start_go_a: assert property (sfr_wr_i && conv_on && sfr_addr_i == ADDR_ADM0 && !s_r.run && s_r.cmp_en
		&& sfr_wmask_i[ADM0_START] && sfr_wdata_i[ADM0_START] |=> s_r.run && afe_o.sample)
		else $error("start did not begin sampling");
	abort_stop_a: assert property (sfr_wr_i && conv_on && sfr_addr_i == ADDR_ADM0 && sfr_wmask_i[ADM0_START]
		&& !sfr_wdata_i[ADM0_START] |=> !s_r.run && s_r.st == ST_IDLE)
		else $error("written zero did not stop conversion");

	// routing
	dis_route_a: assert property (!conv_on
		|-> analog_route_o == 11'h000 && !afe_o.int_ref_sel)
		else $error("disabled converter routes a source");
	ref_route_a: assert property (conv_on && s_r.ref_sel
		|-> analog_route_o == 11'h000 && afe_o.int_ref_sel)
		else $error("internal reference not routed alone");
	pin_route_a: assert property (conv_on && !s_r.ref_sel && s_r.chan < 4'hB
		|-> $onehot(analog_route_o))
		else $error("valid channel not routed to one pin");

	// sequencing
	run_idle_a: assert property (!s_r.run
		|-> s_r.st == ST_IDLE)
		else $error("sequencer busy without start");
	sample_run_a: assert property (afe_o.sample
		|-> s_r.run && conv_on)
		else $error("sampling outside a conversion");
	sample_cnt_a: assert property (s_r.st == ST_SAMPLE
		|-> s_r.cnt <= SAMPLE_LAST)
		else $error("sample counter out of range");
	step_cnt_a: assert property (s_r.st == ST_TRIAL
		|-> s_r.cnt <= STEP_LAST && s_r.idx <= IDX_MSB)
		else $error("step counter or index out of range");
	trial_bits_a: assert property (s_r.st == ST_TRIAL
		|-> s_r.sar[s_r.idx] && (s_r.sar & ((10'h001 << s_r.idx) - 10'h001)) == 10'h000)
		else $error("trial bit or lower bits wrong");
	irq_src_a: assert property (conversion_end_irq_o
		|-> $past(done))
		else $error("end interrupt without a finished conversion");
	end_clear_a: assert property (done && s_nxt.pce[PCE_CONV_EN]
		|=> s_r.st == ST_IDLE && !afe_o.sample)
		else $error("sequencer not idle after end");

	conv10_c: cover property (done && !s_r.res8);
	conv8_c: cover property (done && s_r.res8);
	abort_c: cover property (s_r.st == ST_TRIAL ##1 s_r.st == ST_IDLE && !$past(done));
	intref_c: cover property (done && afe_o.int_ref_sel);
	dis_mid_c: cover property (s_r.st == ST_TRIAL && !s_nxt.pce[PCE_CONV_EN]);
endmodule
`default_nettype wire

/* File: testbench/afe_model.sv */
// behavioural analog front end: sample-hold, tap generator and comparator
`timescale 1ns/1ps
`default_nettype none
module afe_model
	import sar_adc_pkg::*;
(
	input wire logic core_clk_i,
	input wire afe_ctrl_t afe_i,
	input wire logic [10:0][9:0] pin_v_i,
	input wire logic [9:0] ref_v_i,
	output logic cmp_o
);
	logic [9:0] held_r = 10'h000;
	logic junk_r = 1'b0;
	always @(posedge core_clk_i) begin
		junk_r <= ~junk_r;
		if (afe_i.sample) begin
			held_r <= afe_i.int_ref_sel ? ref_v_i : pin_v_i[afe_i.chan_sel];
		end
	end
	// while tracking, the comparator output means nothing, so it toggles
	assign cmp_o = afe_i.sample ? junk_r : (held_r >= afe_i.tap);
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// self-checking testbench of the converter sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
	import sar_adc_pkg::*;
	logic core_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic cmp;
	logic [19:0] addr = 20'h00000;
	logic [7:0] wm = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [15:0] rdata;
	afe_ctrl_t afe;
	logic [10:0] route;
	logic cen;
	logic irq;
	logic [10:0][9:0] pin_v = '0;
	logic [9:0] ref_v = 10'h000;
	int n_fail = 0;
	int checked = 0;
	int k;
	logic [7:0] csel_t [0:6] = '{8'h00, 8'h0A, 8'h03, 8'h80, 8'h01, 8'h02, 8'h0A};
	logic r8_t [0:6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	logic [9:0] v_t [0:6] = '{10'h000, 10'h3FF, 10'h200, 10'h1FF, 10'h2AB, 10'h157, 10'h3FF};

	sar_adc_sequencer i_dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
		.sfr_wmask_i(wm), .sfr_wdata_i(wd), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .cmp_i(cmp), .afe_o(afe),
		.analog_route_o(route), .conv_clock_enable_o(cen), .conversion_end_irq_o(irq));
	afe_model i_afe (.core_clk_i(core_clk_i), .afe_i(afe), .pin_v_i(pin_v), .ref_v_i(ref_v), .cmp_o(cmp));

	initial forever #2.5 core_clk_i = ~core_clk_i;

	task results;
		if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [19:0] a, input logic [7:0] m, input logic [7:0] d);
		@(negedge core_clk_i);
		addr = a; wm = m; wd = d; wr = 1'b1;
		@(negedge core_clk_i);
		wr = 1'b0;
	endtask
	task rd_chk(input logic [19:0] a, input logic [15:0] exp);
		@(negedge core_clk_i);
		addr = a; rd = 1'b1;
		@(negedge core_clk_i);
		rd = 1'b0;
		chk(rdata, exp);
	endtask
	// waits for an end pulse over a bounded window, counting cycles in k; a missing one is reported by the caller
	task wait_irq(input int lim);
		k = 0;
		while (irq !== 1'b1 && k < lim) begin
			@(negedge core_clk_i);
			k++;
		end
	endtask
	task conv(input logic [7:0] csel, input logic r8, input logic [9:0] v);
		logic [9:0] e;
		e = r8 ? (v & 10'h3FC) : v;
		if (csel[7]) ref_v = v;
		else pin_v[csel[3:0]] = v;
		wr_reg(ADDR_MODE2, 8'hFF, {7'h00, r8});
		wr_reg(ADDR_CHAN_SEL, 8'hFF, csel);
		wr_reg(ADDR_ADM0, 8'h01, 8'h01);
		chk({5'h00, route}, csel[7] ? 16'h0000 : (16'h0001 << csel[3:0]));
		chk({15'h0000, afe.int_ref_sel}, {15'h0000, csel[7]});
		wr_reg(ADDR_ADM0, 8'h80, 8'h80);
		wait_irq(200);
		chk({15'h0000, irq}, 16'h0001);
		if (k >= 200) results();
		rd_chk(ADDR_RES_WORD, {e, 6'h00});
		rd_chk(ADDR_RES_BYTE, {8'h00, e[9:2]});
		rd_chk(ADDR_ADM0, 16'h0001);
	endtask

	initial begin
		repeat (20) @(negedge core_clk_i);
		sys_rst_i = 1'b0;
		rd_chk(ADDR_PCLK_EN, 16'h0000);
		wr_reg(ADDR_CHAN_SEL, 8'hFF, 8'h05);
		wr_reg(ADDR_PCLK_EN, 8'h20, 8'hFF);
		rd_chk(ADDR_PCLK_EN, 16'h0020);
		chk({15'h0000, cen}, 16'h0001);
		rd_chk(ADDR_CHAN_SEL, 16'h0000);
		for (int i = 0; i < 7; i++) conv(csel_t[i], r8_t[i], v_t[i]);
		wr_reg(ADDR_ADM0, 8'h80, 8'h80);
		repeat (12) @(negedge core_clk_i);
		wr_reg(ADDR_ADM0, 8'h80, 8'h00);
		wait_irq(100);
		chk(k[15:0], 16'h0064);
		rd_chk(ADDR_ADM0, 16'h0001);
		wr_reg(ADDR_ADM0, 8'hFF, 8'h00);
		wr_reg(ADDR_ADM0, 8'h80, 8'h80);
		rd_chk(ADDR_ADM0, 16'h0000);
		wr_reg(ADDR_PCLK_EN, 8'hFF, 8'h00);
		chk({15'h0000, cen}, 16'h0000);
		rd_chk(ADDR_RES_WORD, 16'h0000);
		wr_reg(ADDR_ADM0, 8'hFF, 8'h01);
		wr_reg(ADDR_PCLK_EN, 8'h20, 8'h20);
		rd_chk(ADDR_ADM0, 16'h0000);
		rd_chk(ADDR_CHAN_SEL, 16'h0000);
		rd_chk(20'hFFFFF, 16'h0000);
		results();
	end
endmodule
`default_nettype wire
